// ==== verilog/scm_pkg.sv ====
// Purpose: Shared types, constants and helpers for the sensor correction math
// Assumes: Raw words two's complement, coefficients sign-magnitude, 24 bits
// Notes:   Internal terms are 26-bit signed, sums are formed 28 bits wide
package scm_pkg;

  // ---------------------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------------------
  localparam int RW    = 24;  // Raw, coefficient and result word width
  localparam int DW    = 26;  // Clamped intermediate width
  localparam int SW    = 28;  // Sum width before clamping
  localparam int NCOEF = 12;  // Number of coefficient words
  localparam int SH_NARROW = 21;  // Scaling of 4*coef/2^23
  localparam int SH_WIDE   = 23;  // Scaling of x/2^23
  localparam int STAT_SAT_BIT = 0;  // Saturation bit of the status byte

  // ---------------------------------------------------------------------------
  // Clamp limits and offsets
  // ---------------------------------------------------------------------------
  localparam logic signed [DW-1:0] LIM_HI = 26'sh1FFFFFF;  // 2^25-1
  localparam logic signed [DW-1:0] LIM_LO = 26'sh2000000;  // -2^25
  localparam logic signed [SW-1:0] SUM_HI = 28'sh1FFFFFF;  // 2^25-1
  localparam logic signed [SW-1:0] SUM_LO = 28'shE000000;  // -2^25
  localparam logic signed [SW-1:0] ONE    = 28'sh0800000;  // 2^23
  localparam logic signed [SW-1:0] ZERO   = 28'sh0000000;  // Lower output bound
  localparam logic signed [SW-1:0] OUT_HI = 28'sh0FFFFFF;  // 2^24-1

  // ---------------------------------------------------------------------------
  // Coefficient indices inside the flattened coefficient word
  // ---------------------------------------------------------------------------
  localparam int C_SGAIN = 0;   // sensor_gain_coef
  localparam int C_SOFF  = 1;   // sensor_offset_coef
  localparam int C_TCG   = 2;   // temp_gain_drift_coef
  localparam int C_TCO   = 3;   // temp_offset_drift_coef
  localparam int C_GDSO  = 4;   // gain_drift_second_order
  localparam int C_ODSO  = 5;   // offset_drift_second_order
  localparam int C_SSO   = 6;   // sensor_second_order
  localparam int C_SADJ  = 7;   // sensor_post_adjust
  localparam int C_TGAIN = 8;   // temp_gain_coef
  localparam int C_TOFF  = 9;   // temp_offset_coef
  localparam int C_TSO   = 10;  // temp_second_order
  localparam int C_TADJ  = 11;  // temp_post_adjust

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  // Clamped term with its saturation mark
  typedef struct packed {
    logic                 sat;
    logic signed [DW-1:0] val;
  } scm_clip_t;

  // Coefficient set, sign-magnitude words; last field sits at index 0
  typedef struct packed {
    logic [RW-1:0] temp_post_adjust;
    logic [RW-1:0] temp_second_order;
    logic [RW-1:0] temp_offset_coef;
    logic [RW-1:0] temp_gain_coef;
    logic [RW-1:0] sensor_post_adjust;
    logic [RW-1:0] sensor_second_order;
    logic [RW-1:0] offset_drift_second_order;
    logic [RW-1:0] gain_drift_second_order;
    logic [RW-1:0] temp_offset_drift_coef;
    logic [RW-1:0] temp_gain_drift_coef;
    logic [RW-1:0] sensor_offset_coef;
    logic [RW-1:0] sensor_gain_coef;
  } scm_coef_t;

  // Finished measurement
  typedef struct packed {
    logic [7:0]    status;
    logic [RW-1:0] sensor;
    logic [RW-1:0] temp;
  } scm_result_t;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Sign-extend a term to sum width
  function automatic logic signed [SW-1:0] scm_ext(input logic signed [DW-1:0] x);
    return SW'(x);
  endfunction

  // Four times a term, at sum width
  function automatic logic signed [SW-1:0] scm_x4(input logic signed [DW-1:0] x);
    return SW'(x) <<< 2;
  endfunction

  // Clamp a sum into [lo, hi] and mark it when it had to be cut
  function automatic scm_clip_t scm_clip(input logic signed [SW-1:0] v,
                                         input logic signed [SW-1:0] lo,
                                         input logic signed [SW-1:0] hi);
    scm_clip_t r;
    r.sat = (v > hi) || (v < lo);
    r.val = (v > hi) ? DW'(hi) : (v < lo) ? DW'(lo) : v[DW-1:0];
    return r;
  endfunction

endpackage

// ==== verilog/scm_sm_to_tc.sv ====
// Purpose: Sign-magnitude coefficient word to 26-bit two's complement
// Assumes: Bit 23 is the sign, bits 22..0 the magnitude
// Notes:   Negative zero maps to zero
`timescale 1ns/1ps
module scm_sm_to_tc (
  // Check clock
  input  wire logic                            sys_clk,
  input  wire logic                            rst_b,
  // Conversion
  input  wire logic [scm_pkg::RW-1:0]          coef_sm,
  output logic signed [scm_pkg::DW-1:0]        coef_tc
);
  import scm_pkg::*;

  // ---------------------------------------------------------------------------
  // Conversion
  // ---------------------------------------------------------------------------
  logic signed [DW-1:0] mag;  // Magnitude, zero-extended

  // Negate the magnitude when the sign bit is set
  always_comb begin
    mag     = DW'(signed'({1'b0, coef_sm[RW-2:0]}));
    coef_tc = coef_sm[RW-1] ? -mag : mag;
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_sm_sign;
    @(posedge sys_clk) disable iff (!rst_b)
    (coef_sm[RW-2:0] != '0) |-> ((coef_tc < 0) == coef_sm[RW-1]) &&
                                 ((coef_tc < 0 ? -coef_tc : coef_tc) == mag);
  endproperty
  a_sm_sign: assert property (p_sm_sign) else $error("coefficient sign lost"); // RULE19

endmodule // scm_sm_to_tc

// ==== verilog/scm_mul_clip.sv ====
// Purpose: Signed multiply, power-of-two scaling and clamp to +/-2^25
// Assumes: Both operands already 26-bit signed
// Notes:   Scaling is an arithmetic shift, so it rounds toward minus infinity
`timescale 1ns/1ps
module scm_mul_clip (
  // Check clock
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // Operands
  input  wire logic signed [scm_pkg::DW-1:0] op_a,
  input  wire logic signed [scm_pkg::DW-1:0] op_b,
  input  wire logic                       shift_wide,
  // Result
  output scm_pkg::scm_clip_t              res
);
  import scm_pkg::*;

  // ---------------------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------------------
  logic signed [2*DW-1:0] prod;    // Full product
  logic signed [2*DW-1:0] scaled;  // Product after scaling

  // Shift before clamping, so the clamp sees the scaled value
  // RULE22: arithmetic shift, then clamp
  always_comb begin
    prod   = op_a * op_b;
    scaled = shift_wide ? (prod >>> SH_WIDE) : (prod >>> SH_NARROW);
    res.sat = (scaled > (2*DW)'(LIM_HI)) || (scaled < (2*DW)'(LIM_LO));
    if (scaled > (2*DW)'(LIM_HI)) begin
      res.val = LIM_HI;
    end else if (scaled < (2*DW)'(LIM_LO)) begin
      res.val = LIM_LO;
    end else begin
      res.val = scaled[DW-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic signed [2*DW-1:0] rem;   // Remainder left by the scaling
  logic signed [2*DW-1:0] unit;  // Weight of one result step

  // Helper for the floor check
  always_comb begin
    unit = shift_wide ? ((2*DW)'(1) <<< SH_WIDE) : ((2*DW)'(1) <<< SH_NARROW);
    rem  = prod - ((2*DW)'(res.val) * unit);
  end

  property p_floor_scale;
    @(posedge sys_clk) disable iff (!rst_b)
    !res.sat |-> (rem >= 0) && (rem < unit);
  endproperty
  a_floor_scale: assert property (p_floor_scale) else $error("scaling not floor"); // RULE22

  property p_clip_side;
    @(posedge sys_clk) disable iff (!rst_b)
    res.sat |-> (prod > 0) ? (res.val == LIM_HI) : (res.val == LIM_LO);
  endproperty
  a_clip_side: assert property (p_clip_side) else $error("clamp wrong bound"); // RULE2

endmodule // scm_mul_clip

// ==== verilog/scm_core.sv ====
// Purpose: Sequential sensor and temperature correction datapath
// Assumes: Inputs held stable only in the cycle start is taken
// Notes:   One multiplier is shared; a measurement takes twelve cycles
//
// Overview of operation
// RULE1: Saturation still yields result, flagged status bit0
// RULE2: Every intermediate clamped to signed 2^25 range
// RULE3: All correction arithmetic uses integer scaling
// RULE4: Curve select chooses parabolic or S-shaped
// RULE5: Calibrator should normally choose parabolic shape
// RULE6: Raw inputs and coefficients treated as signed
// RULE7: Gain temperature factor with drift terms
// RULE8: Offset corrected sum with drift terms
// RULE9: Parabolic intermediate plus 2^23, kept positive
// RULE10: Parabolic sensor output clamped to 24 bits
// RULE11: S-shaped intermediate without offset, signed clamp
// RULE12: S-shaped output uses absolute intermediate
// RULE13: Delivered results are unsigned values
// RULE14: Temperature second order always parabolic
// RULE15: Temperature intermediate clamped to 0..2^25-1
// RULE16: Corrected temperature with post adjust, positive
// RULE17: All results delivered as 24-bit words
// RULE18: Raw words are two's complement fractions
// RULE19: Coefficients stored as sign-magnitude words
// RULE20: Results are unsigned fractions, bit23 weighs one
// RULE21: Alarm thresholds share corrected result format
// RULE22: Scaling is arithmetic shift before clamp
`timescale 1ns/1ps
module scm_core (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Measurement request
  input  wire logic                   start,
  input  wire logic                   curve_shape_select,
  input  wire logic [scm_pkg::RW-1:0] sensor_raw,
  input  wire logic [scm_pkg::RW-1:0] temp_raw,
  input  scm_pkg::scm_coef_t          coef,
  // Measurement answer
  output logic                        busy,
  output logic                        result_valid,
  output scm_pkg::scm_result_t        result
);
  import scm_pkg::*;

  // ---------------------------------------------------------------------------
  // Types and signals
  // ---------------------------------------------------------------------------
  // One state per multiplication
  typedef enum logic [11:0] {
    S_IDLE = 12'h001,
    S_K1A  = 12'h002,
    S_K1B  = 12'h004,
    S_K2A  = 12'h008,
    S_K2B  = 12'h010,
    S_ZA   = 12'h020,
    S_ZB   = 12'h040,
    S_SA   = 12'h080,
    S_SB   = 12'h100,
    S_TA   = 12'h200,
    S_TB   = 12'h400,
    S_TC   = 12'h800
  } scm_fsm_t;

  // Whole state of the block
  typedef struct packed {
    scm_fsm_t                         fsm;    // Step in progress
    logic                             curve;  // Latched shape select
    logic signed [DW-1:0]             t_raw;  // Latched temperature
    logic signed [DW-1:0]             s_raw;  // Latched sensor
    logic [NCOEF-1:0][DW-1:0]         cf;     // Latched coefficients
    logic signed [DW-1:0]             tmp;    // Scratch term
    logic signed [DW-1:0]             k1;     // Gain factor, later sensor result
    logic signed [DW-1:0]             k2;     // Offset corrected sum
    logic signed [DW-1:0]             z;      // Sensor intermediate
    logic signed [DW-1:0]             zt;     // Temperature intermediate
    logic                             sat;    // Saturation seen so far
    logic                             busy;   // Calculation running
    logic                             valid;  // Result pulse
    scm_result_t                      res;    // Delivered words
  } scm_core_state_t;

  scm_core_state_t          st_reg;      // Registered state
  scm_core_state_t          st_next;     // Next state
  logic [NCOEF-1:0][DW-1:0] cf_tc;       // Converted coefficients
  logic signed [DW-1:0]     op_a;        // Multiplier operand a
  logic signed [DW-1:0]     op_b;        // Multiplier operand b
  logic                     shift_wide;  // Scale by 2^23, else 2^21
  scm_clip_t                mul_res;     // Scaled, clamped product
  scm_clip_t                abs_z;       // |z|, clamped
  scm_clip_t                t_sum;       // temp_raw + 4*temp_offset_coef

  // ---------------------------------------------------------------------------
  // Coefficient conversion and shared multiplier
  // ---------------------------------------------------------------------------
  // RULE19: decode sign-magnitude words
  for (genvar i = 0; i < NCOEF; i++) begin : g_cv
    scm_sm_to_tc u_cv (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .coef_sm (coef[i*RW +: RW]),
      .coef_tc (cf_tc[i])
    );
  end

  // One product per state through the shared multiplier
  scm_mul_clip u_mul (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .op_a       (op_a),
    .op_b       (op_b),
    .shift_wide (shift_wide),
    .res        (mul_res)
  );

  // ---------------------------------------------------------------------------
  // Operand selection
  // ---------------------------------------------------------------------------
  // Pick the product of the current step; 4*c/2^23 becomes c scaled by 2^21
  always_comb begin
    // RULE12: magnitude of the S-shaped term
    abs_z = scm_clip((st_reg.z >= 0) ? scm_ext(st_reg.z) : -scm_ext(st_reg.z), SUM_LO, SUM_HI);
    // RULE15: inner temperature sum
    t_sum = scm_clip(scm_ext(st_reg.t_raw) + scm_x4(st_reg.cf[C_TOFF]), SUM_LO, SUM_HI);
    op_a       = '0;
    op_b       = '0;
    shift_wide = 1'b0;
    unique case (st_reg.fsm)
      S_K1A: begin
        op_a = st_reg.cf[C_GDSO];
        op_b = st_reg.t_raw;
      end
      S_K1B, S_K2B: begin
        op_a       = st_reg.t_raw;
        op_b       = st_reg.tmp;
        shift_wide = 1'b1;
      end
      S_K2A: begin
        op_a = st_reg.cf[C_ODSO];
        op_b = st_reg.t_raw;
      end
      S_ZA: begin
        op_a       = st_reg.k1;
        op_b       = st_reg.k2;
        shift_wide = 1'b1;
      end
      S_ZB: begin
        op_a = st_reg.cf[C_SGAIN];
        op_b = st_reg.tmp;
      end
      S_SA: begin
        // RULE4: shape decides the second-order operand
        op_a = st_reg.cf[C_SSO];
        op_b = st_reg.curve ? abs_z.val : st_reg.z;
      end
      S_SB: begin
        op_a       = st_reg.z;
        op_b       = st_reg.tmp;
        shift_wide = 1'b1;
      end
      S_TA: begin
        op_a = st_reg.cf[C_TGAIN];
        op_b = t_sum.val;
      end
      S_TB: begin
        op_a = st_reg.cf[C_TSO];
        op_b = st_reg.zt;
      end
      S_TC: begin
        op_a       = st_reg.zt;
        op_b       = st_reg.tmp;
        shift_wide = 1'b1;
      end
      default: begin // Idle or illegal: multiplier unused
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // RULE3: integer adds and clamps after each product
  always_comb begin
    scm_clip_t c;   // Clamp of this step
    scm_clip_t c2;  // Extra clamp where a step has two
    c       = '0;
    c2      = '0;
    st_next = st_reg;
    st_next.valid = 1'b0;
    unique case (st_reg.fsm)
      S_IDLE: begin
        // Requests while busy are not seen, the machine is elsewhere
        if (start) begin
          st_next.fsm  = S_K1A;
          st_next.busy = 1'b1;
          st_next.sat  = 1'b0;
          st_next.curve = curve_shape_select;
          // RULE6: signed inputs, sign extended
          // RULE18: raw words are two's complement
          st_next.s_raw = DW'(signed'(sensor_raw));
          st_next.t_raw = DW'(signed'(temp_raw));
          st_next.cf    = cf_tc;
        end
      end
      S_K1A: begin
        // RULE7: inner drift sum of the gain factor
        c = scm_clip(scm_ext(mul_res.val) + scm_x4(st_reg.cf[C_TCG]), SUM_LO, SUM_HI);
        st_next.tmp = c.val;
        st_next.fsm = S_K1B;
      end
      S_K1B: begin
        // RULE7: add unity gain
        c = scm_clip(ONE + scm_ext(mul_res.val), SUM_LO, SUM_HI);
        st_next.k1  = c.val;
        st_next.fsm = S_K2A;
      end
      S_K2A: begin
        // RULE8: inner drift sum of the offset
        c = scm_clip(scm_ext(mul_res.val) + scm_x4(st_reg.cf[C_TCO]), SUM_LO, SUM_HI);
        st_next.tmp = c.val;
        st_next.fsm = S_K2B;
      end
      S_K2B: begin
        // RULE8: offset plus raw, then drift
        c2 = scm_clip(scm_x4(st_reg.cf[C_SOFF]) + scm_ext(st_reg.s_raw), SUM_LO, SUM_HI);
        c  = scm_clip(scm_ext(c2.val) + scm_ext(mul_res.val), SUM_LO, SUM_HI);
        st_next.k2  = c.val;
        st_next.fsm = S_ZA;
      end
      S_ZA: begin
        st_next.tmp = mul_res.val;
        st_next.fsm = S_ZB;
      end
      S_ZB: begin
        if (st_reg.curve) begin
          // RULE11: no offset, signed clamp only
          st_next.z = mul_res.val;
        end else begin
          // RULE9: add 2^23, keep positive
          c = scm_clip(scm_ext(mul_res.val) + ONE, ZERO, SUM_HI);
          st_next.z = c.val;
        end
        st_next.fsm = S_SA;
      end
      S_SA: begin
        c2 = st_reg.curve ? abs_z : '0;
        c  = scm_clip(scm_ext(mul_res.val) + ONE, SUM_LO, SUM_HI);
        st_next.tmp = c.val;
        st_next.fsm = S_SB;
      end
      S_SB: begin
        // RULE10: parabolic output with post adjust
        // RULE12: S-shaped output recentred by 2^23
        c = scm_clip(scm_ext(mul_res.val) + (st_reg.curve ? ONE : ZERO) +
                     scm_ext(st_reg.cf[C_SADJ]), ZERO, OUT_HI);
        st_next.k1  = c.val;
        st_next.fsm = S_TA;
      end
      S_TA: begin
        // RULE14: temperature path ignores the shape
        // RULE15: gain, then 2^23, kept in 0..2^25-1
        c2 = t_sum;
        c  = scm_clip(scm_ext(mul_res.val) + ONE, ZERO, SUM_HI);
        st_next.zt  = c.val;
        st_next.fsm = S_TB;
      end
      S_TB: begin
        c = scm_clip(scm_ext(mul_res.val) + ONE, SUM_LO, SUM_HI);
        st_next.tmp = c.val;
        st_next.fsm = S_TC;
      end
      S_TC: begin
        // RULE16: final temperature with post adjust
        c = scm_clip(scm_ext(mul_res.val) + scm_ext(st_reg.cf[C_TADJ]), ZERO, OUT_HI);
        // RULE13: both outputs unsigned
        // RULE17: delivered as 24-bit words
        // RULE20: unsigned fractions
        // RULE21: same format as alarm thresholds
        st_next.res.temp   = c.val[RW-1:0];
        st_next.res.sensor = st_reg.k1[RW-1:0];
        st_next.valid = 1'b1;
        st_next.busy  = 1'b0;
        st_next.fsm   = S_IDLE;
      end
      default: begin // Illegal code: back to idle
        st_next.fsm  = S_IDLE;
        st_next.busy = 1'b0;
      end
    endcase
    // RULE2: any clamp hit is remembered
    if (st_reg.fsm != S_IDLE) begin
      st_next.sat = st_reg.sat | mul_res.sat | c.sat | c2.sat;
    end
    // RULE1: result always delivered, flag carried along
    if (st_reg.fsm == S_TC) begin
      st_next.res.status = '0;
      st_next.res.status[STAT_SAT_BIT] = st_next.sat;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg     <= '0;
      st_reg.fsm <= S_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
  // Outputs straight from the state register
  assign busy         = st_reg.busy;
  assign result_valid = st_reg.valid;
  assign result       = st_reg.res;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_latency;
    @(posedge sys_clk) disable iff (!rst_b) (start && st_reg.fsm == S_IDLE) |-> ##12 result_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("result late or early"); // RULE17
  property p_sat_flag;
    @(posedge sys_clk) disable iff (!rst_b)
    (st_reg.fsm != S_IDLE && mul_res.sat) |-> ##[1:11] (result_valid && result.status[STAT_SAT_BIT]);
  endproperty
  a_sat_flag: assert property (p_sat_flag) else $error("saturation not flagged"); // RULE1
  property p_para_pos;
    @(posedge sys_clk) disable iff (!rst_b) (st_reg.fsm == S_SA && !st_reg.curve) |-> (st_reg.z >= 0);
  endproperty
  a_para_pos: assert property (p_para_pos) else $error("parabolic term negative"); // RULE9
  property p_zt_range;
    @(posedge sys_clk) disable iff (!rst_b) (st_reg.fsm == S_TB) |-> (st_reg.zt >= 0);
  endproperty
  a_zt_range: assert property (p_zt_range) else $error("temperature term negative"); // RULE15
  property p_shape_operand;
    @(posedge sys_clk) disable iff (!rst_b) (st_reg.fsm == S_SA) |-> (st_reg.curve ? (op_b >= 0) : (op_b == st_reg.z));
  endproperty
  a_shape_operand: assert property (p_shape_operand) else $error("wrong shape operand"); // RULE4
  property p_result_hold;
    @(posedge sys_clk) disable iff (!rst_b) !result_valid |=> $stable(result) || result_valid;
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved early"); // RULE13

endmodule // scm_core

// ==== dv/scm_host_model.sv ====
// Purpose: Host side that collects finished measurements
// Assumes: result_valid is a one-cycle pulse
// Notes:   Keeps the last word and a running count
`timescale 1ns/1ps
module scm_host_model (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst_b,
  // Answer from the block
  input  wire logic           result_valid,
  input  scm_pkg::scm_result_t result,
  // Collected data
  output scm_pkg::scm_result_t last_reg,
  output int                  n_seen
);
  import scm_pkg::*;
  // Take each word in its only valid cycle; result itself holds until the next result
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_reg <= '0;
      n_seen   <= 0;
    end else if (result_valid) begin
      last_reg <= result;
      n_seen   <= n_seen + 1;
    end
  end
endmodule // scm_host_model

// ==== dv/sensor_correction_math_test.sv ====
// Purpose: Self-checking bench for the correction datapath
// Assumes: Expected words worked out by hand from the equations
// Notes:   Coefficients chosen as powers of two to keep sums exact, except in t_floor
`timescale 1ns/1ps
module sensor_correction_math_test;
  import scm_pkg::*;
  logic            sys_clk = 0;
  logic            rst_b = 0;
  logic            start = 0;
  logic            curve_shape_select = 0;
  logic [RW-1:0]   sensor_raw = '0;
  logic [RW-1:0]   temp_raw = '0;
  scm_coef_t       coef = '0;
  logic            busy;
  logic            result_valid;
  scm_result_t     result;
  scm_result_t     last_reg;
  int              n_seen;
  int              n_fail = 0;
  int              compares = 0;
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  scm_core DUT (.sys_clk(sys_clk), .rst_b(rst_b), .start(start), .curve_shape_select(curve_shape_select),
    .sensor_raw(sensor_raw), .temp_raw(temp_raw), .coef(coef), .busy(busy), .result_valid(result_valid),
    .result(result));
  scm_host_model host (.sys_clk(sys_clk), .rst_b(rst_b), .result_valid(result_valid), .result(result),
    .last_reg(last_reg), .n_seen(n_seen));
  task automatic check(input logic [RW-1:0] seen, input logic [RW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One request; poke raises start while busy, which must be ignored
  task automatic measure(input logic cv, input logic [RW-1:0] s, t, es, et, input logic [7:0] est,
                         input logic poke);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    curve_shape_select = cv;
    sensor_raw = s;
    temp_raw = t;
    start = 1;
    @(posedge sys_clk);
    #1;
    start = 0;
    while (result_valid !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
      start = poke && n == 2;
      if (start) sensor_raw = '0;
    end
    check(RW'(n), RW'(11));
    check(RW'(busy), '0);
    check(result.sensor, es);
    check(result.temp, et);
    check(RW'(result.status), RW'(est));
  endtask
  task automatic t_shape;
    coef = '0;
    coef.sensor_gain_coef = 24'h200000;
    coef.sensor_second_order = 24'h200000;
    coef.temp_gain_coef = 24'h200000;
    coef.temp_offset_coef = 24'h000001;
    measure(0, 24'h100000, '0, 24'hFFFFFF, 24'h800004, 8'h01, 0);
    measure(1, 24'h100000, '0, 24'h920000, 24'h800004, 8'h00, 0);
    measure(1, 24'hF00000, '0, 24'h6E0000, 24'h800004, 8'h00, 0);
    measure(1, 24'hFFFFFF, '0, 24'h7FFFFE, 24'h800004, 8'h00, 0);
    $display("t_shape done");
  endtask
  // calibrated setups use the parabolic shape
  task automatic t_drift;
    coef = '0;
    coef.sensor_gain_coef = 24'h200000;
    coef.temp_gain_drift_coef = 24'h200000;
    coef.temp_offset_drift_coef = 24'h200000;
    coef.temp_gain_coef = 24'h200000;
    coef.sensor_post_adjust = 24'h800010;
    coef.temp_post_adjust = 24'h000020;
    measure(0, 24'h100000, 24'h400000, 24'hF7FFF0, 24'hC00020, 8'h00, 0);
    measure(0, 24'h100000, 24'h400000, 24'hF7FFF0, 24'hC00020, 8'h00, 1);
    $display("t_drift done");
  endtask
  task automatic t_floor;
    coef = '0;
    coef.sensor_gain_coef = 24'h200000;
    coef.sensor_post_adjust = 24'hFFFFFF;
    coef.temp_post_adjust = 24'hFFFFFF;
    measure(0, 24'hF00000, '0, 24'h000000, 24'h000001, 8'h01, 0);
    coef.sensor_second_order = 24'h7FFFFF;
    measure(0, 24'h100000, '0, 24'hFFFFFF, 24'h000001, 8'h01, 0);
    $display("t_floor done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst_b = 1;
    t_shape();
    t_drift();
    t_floor();
    @(posedge sys_clk);
    #1;
    check(RW'(n_seen), RW'(8));
    check(last_reg.temp, 24'h000001);
    report_and_stop();
  end
endmodule // sensor_correction_math_test
